// ---- rtl/sss_capture.sv ----
// Strap sampler: holds strap levels captured at fundamental reset release.
// Assumes strap pins are stable around release of the fundamental reset.
`timescale 1ns/1ps
module sss_capture
  import sss_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [3:0] mode_pins,
  input  wire logic [6:0] strap_pins,
  sss_strap_if.src        straps
);
  sss_state_t state_reg;
  // Async reset loads constants only; pins are caught on the first edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= SSS_ST_IDLE;
      straps.mode  <= 4'h0;
      straps.bits  <= 8'h00;
      straps.valid <= 1'b0;
    end else begin
      case (state_reg)
        SSS_ST_IDLE: begin
          straps.mode  <= mode_pins;             // [RQ1]
          straps.bits  <= {1'b0, strap_pins};    // [RQ3] [RQ9]
          straps.valid <= 1'b1;
          state_reg    <= SSS_ST_DONE;
        end
        SSS_ST_DONE: state_reg <= SSS_ST_DONE;   // Frozen until next reset
        default:     state_reg <= SSS_ST_IDLE;
      endcase
    end
  end

  // Straps must not move after capture, though the board pins may
  AST_FROZEN: assert property ( // [RQ1]
    @(posedge clock) disable iff (!rst_n)
    straps.valid && $past(straps.valid) |-> $stable(straps.mode))
    else $error("strap mode changed after capture");
  AST_FROZEN_BITS: assert property ( // [RQ3]
    @(posedge clock) disable iff (!rst_n)
    straps.valid && $past(straps.valid) |-> $stable(straps.bits))
    else $error("strap bits changed after capture");
endmodule

// ---- rtl/sss_if.sv ----
// Strap bundle carried from the capture stage into the register module.
// Assumes both ends sit in the core clock domain.
`timescale 1ns/1ps
interface sss_strap_if;
  logic [3:0] mode;
  logic [7:0] bits; // cclk_dn, cclk_up, smb, lane_a, lane_c, refclk, halt, 0
  logic       valid;
  modport src (output mode, output bits, output valid);
  modport dst (input mode, input bits, input valid);
endinterface

// ---- rtl/sss_pkg.sv ----
// Package for the switch status strap capture block.
// Assumes one core clock; register reached at its configuration offset.
package sss_pkg;
  localparam logic [11:0] SSS_SWITCH_STATUS_OFF = 12'h0a0;
  localparam int SSS_MODE_LSB    = 0;
  localparam int SSS_MODE_W      = 4;
  localparam int SSS_CCLK_DN_BIT = 4;
  localparam int SSS_CCLK_UP_BIT = 5;
  localparam int SSS_SMB_SLOW_BIT = 6;
  localparam int SSS_LANE_A_BIT  = 7;
  localparam int SSS_LANE_C_BIT  = 9;
  localparam int SSS_REFCLK_BIT  = 10;
  localparam int SSS_HALT_BIT    = 11;
  localparam int SSS_SCRATCH_LSB = 13;
  localparam int SSS_SCRATCH_W   = 4;
  localparam int SSS_INT_LSB     = 20;
  localparam int SSS_INT_W       = 4;
  localparam logic [3:0] SSS_SCRATCH_RST = 4'h0;
  localparam logic [31:0] SSS_ZERO_WORD = 32'h0000_0000;
  // Operating mode encodings; codes 6 to 15 are reserved
  typedef enum logic [3:0] {
    SSS_MODE_TRANSP      = 4'h0,
    SSS_MODE_TRANSP_INIT = 4'h1,
    SSS_MODE_NTB         = 4'h2,
    SSS_MODE_NTB_INIT    = 4'h3,
    SSS_MODE_FAILOVER    = 4'h4,
    SSS_MODE_FAIL_INIT   = 4'h5
  } sss_mode_t;
  // Capture sequencer, Gray along the usual path
  typedef enum logic [1:0] {
    SSS_ST_IDLE = 2'b00,
    SSS_ST_DONE = 2'b01
  } sss_state_t;
endpackage

// ---- rtl/sss_switch_status.sv ----
// Switch status register with strap capture, scratch and INTx state.
// Assumes rst_n is the fundamental reset and hot_rst_n a synchronous
// active-low hot reset; register access is a single-cycle read/write port.
//
// Summary of operation
// (RQ1) Latch four mode straps at reset exit; read-only in bits 3:0.
// (RQ2) Mode codes 0..5 defined; 6..15 reserved.
// (RQ3) Bit 4 returns captured downstream common-clock strap.
// (RQ4) Bit 5 returns captured upstream common-clock strap.
// (RQ5) Bit 6 returns captured master SMBus slow strap.
// (RQ6) Bit 7 returns captured port A lane swap strap.
// (RQ7) Bit 9 returns captured port C lane swap strap.
// (RQ8) Bit 10 returns captured reference clock select strap.
// (RQ9) Bit 11 returns captured hold-in-reset strap.
// (RQ10) Scratch bits 16:13 writable, zero on fundamental reset, kept on hot.
// (RQ11) Bit 20 reports aggregated INTA level.
// (RQ12) Bits 23:21 report INTB..INTD; bits 31:24 read zero.
// (RQ13) Reserved bits read zero; writes to read-only fields ignored.
`timescale 1ns/1ps
module sss_switch_status
  import sss_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        hot_rst_n,
  input  wire logic [3:0]  operating_mode_straps,
  input  wire logic        common_clock_down,
  input  wire logic        common_clock_up,
  input  wire logic        master_smbus_slow_strap,
  input  wire logic        port_a_lane_swap,
  input  wire logic        port_c_lane_swap,
  input  wire logic        ref_clock_source_select,
  input  wire logic        hold_in_reset_strap,
  input  wire logic [3:0]  intx_state,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             reg_ack,
  output logic             mode_reserved
);
  import sss_pkg::*;

  sss_strap_if straps ();
  logic [3:0]  scratch_reg;
  logic [3:0]  intx_reg;
  logic [31:0] status_word;
  logic        hit;

  // Strap sampling lives in its own module so the pins are seen once
  sss_capture u_cap (
    .clock      (clock),
    .rst_n      (rst_n),
    .mode_pins  (operating_mode_straps),
    .strap_pins ({hold_in_reset_strap, ref_clock_source_select,
                  port_c_lane_swap, port_a_lane_swap,
                  master_smbus_slow_strap, common_clock_up,
                  common_clock_down}),
    .straps     (straps)
  );

  // Single register decode; every other offset reads zero
  assign hit = (reg_addr == SSS_SWITCH_STATUS_OFF);

  // Refuse a field layout where mode or scratch would overlap the field above or
  // the INTx nibble the top byte; the read word is assembled from these constants alone
  if (SSS_MODE_LSB + SSS_MODE_W > SSS_CCLK_DN_BIT ||
      SSS_SCRATCH_LSB + SSS_SCRATCH_W > SSS_INT_LSB ||
      SSS_INT_LSB + SSS_INT_W > 24) begin : g_layout_check
    $error("status field layout overlaps");
  end

  // Scratch only sees the fundamental reset, so a hot reset leaves it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scratch_reg <= SSS_SCRATCH_RST;                          // [RQ10]
    end else if (reg_wr && hit) begin
      scratch_reg <= reg_wdata[SSS_SCRATCH_LSB +: SSS_SCRATCH_W]; // [RQ10]
    end
  end

  // Interrupt levels registered; these do follow hot reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      intx_reg <= 4'h0;
    end else if (!hot_rst_n) begin
      intx_reg <= 4'h0;
    end else begin
      intx_reg <= intx_state;                                 // [RQ11] [RQ12]
    end
  end

  // Assemble the word; everything not placed stays zero
  always_comb begin
    status_word = SSS_ZERO_WORD;                                // [RQ13]
    status_word[SSS_MODE_LSB +: SSS_MODE_W] = straps.mode;      // [RQ1]
    status_word[SSS_CCLK_DN_BIT]  = straps.bits[0];             // [RQ3]
    status_word[SSS_CCLK_UP_BIT]  = straps.bits[1];             // [RQ4]
    status_word[SSS_SMB_SLOW_BIT] = straps.bits[2];             // [RQ5]
    status_word[SSS_LANE_A_BIT]   = straps.bits[3];             // [RQ6]
    status_word[SSS_LANE_C_BIT]   = straps.bits[4];             // [RQ7]
    status_word[SSS_REFCLK_BIT]   = straps.bits[5];             // [RQ8]
    status_word[SSS_HALT_BIT]     = straps.bits[6];             // [RQ9]
    status_word[SSS_SCRATCH_LSB +: SSS_SCRATCH_W] = scratch_reg;
    status_word[SSS_INT_LSB +: SSS_INT_W] = intx_reg;           // [RQ12]
  end

  // Ack answers every access, mapped or not, exactly one cycle later
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_ack <= 1'b0;
    end else begin
      reg_ack <= reg_rd || reg_wr;                              // [RQ13]
    end
  end

  // Read data is zero unless this register is read, so a stale word
  // never lingers on the port for a later unrelated access
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= SSS_ZERO_WORD;
    end else if (reg_rd && hit) begin
      reg_rdata <= status_word;                                 // [RQ1]
    end else begin
      reg_rdata <= SSS_ZERO_WORD;                               // [RQ13]
    end
  end

  // Flags a mode code in the reserved range
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_reserved <= 1'b0;
    end else begin
      mode_reserved <= (straps.mode > SSS_MODE_FAIL_INIT);      // [RQ2]
    end
  end

  // Captured mode comes back unchanged in the low nibble
  AST_MODE_RD: assert property ( // [RQ1]
    @(posedge clock) disable iff (!rst_n)
    reg_rd && hit |=> reg_rdata[3:0] == $past(straps.mode))
    else $error("mode field mismatch");
  // Reserved holes stay zero whatever was written
  AST_RSVD: assert property ( // [RQ13]
    @(posedge clock) disable iff (!rst_n)
    reg_rd && hit |=> reg_rdata[31:24] == 8'h00 &&
      reg_rdata[8] == 1'b0 && reg_rdata[12] == 1'b0 &&
      reg_rdata[19:17] == 3'h0)
    else $error("reserved bits nonzero");
  // A mapped write lands in the scratch field on the taking edge
  AST_SCR_WR: assert property ( // [RQ10]
    @(posedge clock) disable iff (!rst_n)
    reg_wr && hit |=> scratch_reg == $past(reg_wdata[16:13]))
    else $error("scratch write lost");
  // Hot reset alone never touches the scratch field
  AST_SCR_HOT: assert property ( // [RQ10]
    @(posedge clock) disable iff (!rst_n)
    !hot_rst_n && !(reg_wr && hit) |=> $stable(scratch_reg))
    else $error("scratch changed on hot reset");
  // Without a mapped write the scratch field holds its value
  AST_SCR_KEEP: assert property ( // [RQ10]
    @(posedge clock) disable iff (!rst_n)
    !(reg_wr && hit) |=> $stable(scratch_reg))
    else $error("scratch moved without a write");
  // Scratch field read back as stored
  AST_SCR_RD: assert property ( // [RQ10]
    @(posedge clock) disable iff (!rst_n)
    reg_rd && hit |=> reg_rdata[16:13] == $past(scratch_reg))
    else $error("scratch readback mismatch");
  // Interrupt nibble shows the copy held at the taking edge
  AST_INT_RD: assert property ( // [RQ11]
    @(posedge clock) disable iff (!rst_n)
    reg_rd && hit |=> reg_rdata[23:20] == $past(intx_reg))
    else $error("intx state mismatch");
  // The copy follows the wires one cycle late outside hot reset
  AST_INT_FOLLOW: assert property ( // [RQ12]
    @(posedge clock) disable iff (!rst_n)
    hot_rst_n |=> intx_reg == $past(intx_state))
    else $error("intx copy does not follow wires");
  // Hot reset clears the copy, unlike the scratch field
  AST_INT_HOT: assert property ( // [RQ11]
    @(posedge clock) disable iff (!rst_n)
    !hot_rst_n |=> intx_reg == 4'h0)
    else $error("intx copy kept over hot reset");
  // Lower strap bits read back as captured
  AST_STRAP_RD: assert property ( // [RQ3]
    @(posedge clock) disable iff (!rst_n)
    reg_rd && hit |=> reg_rdata[4] == straps.bits[0] &&
      reg_rdata[5] == straps.bits[1] && reg_rdata[6] == straps.bits[2] &&
      reg_rdata[7] == straps.bits[3])
    else $error("low strap bits mismatch");
  // Upper strap bits read back as captured
  AST_STRAP_HI: assert property ( // [RQ7]
    @(posedge clock) disable iff (!rst_n)
    reg_rd && hit |=> reg_rdata[9] == straps.bits[4] &&
      reg_rdata[10] == straps.bits[5] && reg_rdata[11] == straps.bits[6])
    else $error("high strap bits mismatch");
  // Writes never reach the captured strap bits
  AST_RO_WR: assert property ( // [RQ13]
    @(posedge clock) disable iff (!rst_n)
    straps.valid && reg_wr ##1 1'b1 |-> $stable(straps.bits))
    else $error("write disturbed strap");
  // First reserved code is flagged
  AST_MODE_RES: assert property ( // [RQ2]
    @(posedge clock) disable iff (!rst_n)
    straps.valid ##1 straps.mode == 4'h6 |=> mode_reserved)
    else $error("reserved mode not flagged");
  // Flag tracks the captured code over the whole range, both ways
  AST_MODE_OK: assert property ( // [RQ2]
    @(posedge clock) disable iff (!rst_n)
    straps.valid |=>
      mode_reserved == ($past(straps.mode) > SSS_MODE_FAIL_INIT))
    else $error("mode reserved flag wrong");
  // Anything but a mapped read leaves the data port at zero
  AST_ZERO_RD: assert property ( // [RQ13]
    @(posedge clock) disable iff (!rst_n)
    !(reg_rd && hit) |=> reg_rdata == SSS_ZERO_WORD)
    else $error("read data not zero");
  // Every access is acked, refused ones too
  AST_ACK_ON: assert property ( // [RQ13]
    @(posedge clock) disable iff (!rst_n)
    reg_rd || reg_wr |=> reg_ack)
    else $error("access not acked");
  // No ack without an access
  AST_ACK_OFF: assert property ( // [RQ13]
    @(posedge clock) disable iff (!rst_n)
    !(reg_rd || reg_wr) |=> !reg_ack)
    else $error("ack without access");

  // Main scenarios: mapped write, hot reset over live scratch, interrupt
  // read, reserved mode capture and unmapped read
  CV_WR: cover property (@(posedge clock) reg_wr && hit);
  CV_HOT: cover property (@(posedge clock) !hot_rst_n && scratch_reg != 4'h0);
  CV_INT: cover property (@(posedge clock) reg_rd && hit && intx_reg != 4'h0);
  CV_RSVD: cover property (@(posedge clock) mode_reserved);
  CV_MISS: cover property (@(posedge clock) reg_rd && !hit);
endmodule

// ---- tb/sss_strap_board.sv ----
// Board strap model: drives strap levels through fundamental reset.
// Assumes the bench sets the wanted levels before reset is released.
`timescale 1ns/1ps
module sss_strap_board (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [3:0] mode_set,
  input  wire logic [6:0] bits_set,
  output logic      [3:0] mode_pins,
  output logic      [6:0] strap_pins
);
  logic [1:0] settle_reg;
  // Count edges after release; straps hold through the capture edge and one more
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) settle_reg <= 2'h0;
    else if (settle_reg != 2'h3) settle_reg <= settle_reg + 2'h1;
  end
  // Pins then flip, so a design that keeps sampling them is caught
  always_comb begin
    mode_pins  = (settle_reg < 2'h2) ? mode_set : ~mode_set;
    strap_pins = (settle_reg < 2'h2) ? bits_set : ~bits_set;
  end
endmodule

// ---- tb/test_sss_switch_status.sv ----
// Self-checking bench for the switch status register.
// Assumes the single-cycle access port and strap board model.
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module test_sss_switch_status;
  import sss_pkg::*;
  logic        clock = 0, rst_n = 0, hot_rst_n = 1, reg_wr = 0, reg_rd = 0;
  logic [3:0]  mode_set = 4'h0, mode_pins, intx_state = 4'h0, sc, m;
  logic [6:0]  bits_set = 7'h00, strap_pins, b;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, q;
  logic        reg_ack, mode_reserved;
  int          err_total = 0, comparisons = 0;
  sss_strap_board board (.clock(clock), .rst_n(rst_n), .mode_set(mode_set),
    .bits_set(bits_set), .mode_pins(mode_pins), .strap_pins(strap_pins));
  sss_switch_status dut (.clock(clock), .rst_n(rst_n), .hot_rst_n(hot_rst_n),
    .operating_mode_straps(mode_pins), .common_clock_down(strap_pins[0]),
    .common_clock_up(strap_pins[1]), .master_smbus_slow_strap(strap_pins[2]),
    .port_a_lane_swap(strap_pins[3]), .port_c_lane_swap(strap_pins[4]),
    .ref_clock_source_select(strap_pins[5]),
    .hold_in_reset_strap(strap_pins[6]), .intx_state(intx_state),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .mode_reserved(mode_reserved));
  initial begin
    forever #4 clock = ~clock;
  end
  // One access: strobes stand for the taking edge only; the registered
  // answer is read while it stands, then an edge passes so that the
  // next call never re-raises a strobe in the same time step
  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock);
    #1;
    reg_wr = 0;
    reg_rd = 0;
    `CHK(reg_ack, 1'b1)
    r = reg_rdata;
    @(posedge clock);
    #1;
    `CHK(reg_ack, 1'b0)
  endtask
  // Fundamental reset with the given strap levels on the board
  task automatic frst(input logic [3:0] mv, input logic [6:0] bv);
    mode_set = mv;
    bits_set = bv;
    m = mv;
    b = bv;
    sc = 4'h0;
    rst_n = 0;
    repeat (5) @(posedge clock);
    #1 rst_n = 1;
    repeat (2) @(posedge clock);
    #1;
  endtask
  // Read the register and compare against the expected layout
  task automatic rdchk();
    logic [31:0] e;
    e = {8'h00, intx_state, 3'b000, sc, 1'b0, b[6:4], 1'b0, b[3:0], m};
    acc(0, SSS_SWITCH_STATUS_OFF, 32'h0, q);
    `CHK(q, e)
  endtask
  task automatic end_of_test();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog: whole sequence needs well under a thousand cycles
  initial begin
    #40000;
    err_total++;
    end_of_test();
  end
  initial begin
    // Mode codes 0 to 7 and 15, reserved ones too, with alternating strap levels
    for (int i = 0; i < 8; i++) begin
      frst(i[3:0], i[0] ? 7'h55 : 7'h2a);
      rdchk();
      `CHK(mode_reserved, (i > 5))
    end
    frst(4'hf, 7'h7f);
    `CHK(mode_reserved, 1'b1)
    // All-ones write only lands in the scratch field
    acc(1, SSS_SWITCH_STATUS_OFF, 32'hffff_ffff, q);
    sc = 4'hf;
    rdchk();
    acc(1, SSS_SWITCH_STATUS_OFF, 32'h0000_a000, q);
    sc = 4'h5;
    rdchk();
    // Unmapped place: write ignored, read gives zero
    acc(1, 12'h0a4, 32'h0, q);
    acc(0, 12'h0a4, 32'h0, q);
    `CHK(q, SSS_ZERO_WORD)
    rdchk();
    // Hot reset keeps the scratch field
    hot_rst_n = 0;
    repeat (2) @(posedge clock);
    #1 hot_rst_n = 1;
    rdchk();
    // Interrupt levels each one way, then the other
    intx_state = 4'h5;
    repeat (2) @(posedge clock);
    #1 rdchk();
    intx_state = 4'ha;
    repeat (2) @(posedge clock);
    #1 rdchk();
    intx_state = 4'h0;
    frst(4'h3, 7'h00);
    rdchk();
    end_of_test();
  end
endmodule
